// file: bench/host_bus_model.sv
`timescale 1ns/10ps
// host cpu model on the register port
module host_bus_model (
    // clock
    input  wire logic        core_clk,
    // register port
    input  wire logic [15:0] reg_rdata,
    output logic      [15:0] reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_write,
    output logic             reg_read
);
    // idle bus
    initial begin
        reg_addr  = 16'hffff;
        reg_wdata = 16'hffff;
        reg_write = 1'b0;
        reg_read  = 1'b0;
    end

    // one write, taken at the next rising edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge core_clk);
        reg_write = 1'b0;
        reg_addr  = ~a; // released lines show no stale value
        reg_wdata = ~d;
    endtask

    // one read, data valid the cycle after
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge core_clk);
        reg_read = 1'b0;
        reg_addr = ~a;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
endmodule

// file: bench/test_qdc_readout_control_regs.sv
`timescale 1ns/10ps
module test_qdc_readout_control_regs;
    import qdc_regs_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n  = 1'b0;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, v, obs;
    logic reg_write, reg_read, irq_request, module_reset_pulse, fast_clear_open;
    logic any_trigger = 1'b0, accepted_trigger = 1'b0, soft_reset_req = 1'b0;
    logic buffer_empty = 1'b1, buffer_full = 1'b0, end_of_block_word = 1'b0;
    logic [THRESH_W-1:0] events_stored = '0;
    logic [3:0] plugin_type_code = 4'ha; // arbitrary value
    logic pointer_next_event, pointer_next_word, data_reset, memory_test_mode;
    logic synthetic_event_mode, converter_halt, store_overflowed, store_below_threshold;
    logic threshold_window_shift, sliding_scale_enable, sliding_sub_disable, write_empty_events;
    chain_role_e chain_role;
    int n_errors = 0, samples_checked = 0, n_mrst = 0, n_ev = 0, n_wd = 0, n_open = 0;

    // clock, reset
    always #4 core_clk = ~core_clk;
    initial begin
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
    end

    // mode outputs gathered at their bit places
    assign obs = {2'b00, sliding_sub_disable, write_empty_events, 3'b000, threshold_window_shift,
                  sliding_scale_enable, synthetic_event_mode, 1'b0, store_below_threshold,
                  store_overflowed, data_reset, converter_halt, memory_test_mode};

    // pulse and window counters
    always @(posedge core_clk) begin
        if (module_reset_pulse === 1'b1) n_mrst++;
        if (pointer_next_event === 1'b1) n_ev++;
        if (pointer_next_word === 1'b1) n_wd++;
        if (fast_clear_open === 1'b1) n_open++;
    end

    qdc_readout_control_regs i_qdc_readout_control_regs (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .any_trigger(any_trigger), .accepted_trigger(accepted_trigger),
        .soft_reset_req(soft_reset_req), .events_stored(events_stored), .buffer_empty(buffer_empty),
        .buffer_full(buffer_full), .plugin_type_code(plugin_type_code),
        .end_of_block_word(end_of_block_word), .module_reset_pulse(module_reset_pulse),
        .chain_role(chain_role), .irq_request(irq_request), .pointer_next_event(pointer_next_event),
        .pointer_next_word(pointer_next_word), .data_reset(data_reset),
        .memory_test_mode(memory_test_mode), .synthetic_event_mode(synthetic_event_mode),
        .converter_halt(converter_halt), .store_overflowed(store_overflowed),
        .store_below_threshold(store_below_threshold), .threshold_window_shift(threshold_window_shift),
        .sliding_scale_enable(sliding_scale_enable), .sliding_sub_disable(sliding_sub_disable),
        .write_empty_events(write_empty_events), .fast_clear_open(fast_clear_open));

    host_bus_model i_host_bus_model (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        i_host_bus_model.wr(a, d);
    endtask

    task automatic rd_chk(input string name, input logic [15:0] a, input logic [15:0] exp);
        i_host_bus_model.rd(a, v);
        chk(name, 24'(v), 24'(exp));
    endtask

    // one trigger pulse from acquisition
    task automatic trig(input logic acc);
        @(negedge core_clk);
        any_trigger      = 1'b1;
        accepted_trigger = acc;
        @(negedge core_clk);
        any_trigger      = 1'b0;
        accepted_trigger = 1'b0;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_mode();
        rd_chk("mode_reset", OFS_MODE_SET, MODE_RESET_VALUE);
        chk("mode_outs_reset", 24'(obs), 24'(MODE_RESET_VALUE & 16'h37df));
        wr(OFS_MODE_SET, 16'hffff);
        rd_chk("mode_all_set", OFS_MODE_SET, MODE_USED_MASK);
        chk("mode_outs_set", 24'(obs), 24'(MODE_USED_MASK & 16'h37df));
        wr(OFS_MODE_CLEAR, 16'h0004);
        rd_chk("mode_clear_one", OFS_MODE_SET, MODE_USED_MASK & 16'hfffb);
        chk("data_reset_off", 24'(data_reset), 24'h0);
        wr(OFS_MODE_CLEAR, 16'hffff);
        rd_chk("mode_all_clear", OFS_MODE_SET, 16'h0000);
        chk("mode_outs_clear", 24'(obs), 24'h0);
        wr(OFS_MODE_SET, MODE_RESET_VALUE);
        $display("test mode done");
    endtask

    task automatic t_count();
        wr(OFS_COUNT_RESET, 16'h0000);
        trig(1'b0);
        trig(1'b0);
        trig(1'b1);
        rd_chk("count_all_low", OFS_COUNT_LOW, 16'h0003);
        rd_chk("count_high", OFS_COUNT_HIGH, 16'h0000);
        wr(OFS_MODE_CLEAR, 16'h4000);
        trig(1'b0);
        trig(1'b1);
        rd_chk("count_accepted", OFS_COUNT_LOW, 16'h0004);
        @(negedge core_clk) soft_reset_req = 1'b1;
        @(negedge core_clk) soft_reset_req = 1'b0;
        rd_chk("count_soft_reset", OFS_COUNT_LOW, 16'h0000);
        trig(1'b1);
        wr(OFS_MODE_SET, 16'h0004);
        wr(OFS_MODE_CLEAR, 16'h0004);
        rd_chk("count_data_wipe", OFS_COUNT_LOW, 16'h0000);
        trig(1'b1);
        wr(OFS_COUNT_RESET, 16'h0000);
        rd_chk("count_reset_write", OFS_COUNT_LOW, 16'h0000);
        wr(OFS_MODE_SET, 16'h4000);
        $display("test counter done");
    endtask

    task automatic t_irq_status();
        events_stored = 5'd2;
        wr(OFS_IRQ_THRESHOLD, 16'h0003);
        rd_chk("irq_threshold", OFS_IRQ_THRESHOLD, 16'h0003);
        chk("irq_below", 24'(irq_request), 24'h0);
        events_stored = 5'd3;
        repeat (2) @(negedge core_clk);
        chk("irq_equal", 24'(irq_request), 24'h1);
        events_stored = 5'd0;
        wr(OFS_IRQ_THRESHOLD, 16'h0000);
        repeat (2) @(negedge core_clk);
        chk("irq_disabled", 24'(irq_request), 24'h0);
        rd_chk("status_empty", OFS_BUFFER_STATUS, 16'h00a1);
        buffer_empty     = 1'b0;
        buffer_full      = 1'b1;
        plugin_type_code = 4'h6;
        rd_chk("status_full", OFS_BUFFER_STATUS, 16'h0062);
        $display("test irq and status done");
    endtask

    task automatic t_chain_pointer();
        int e0;
        int w0;
        chain_role_e exp_role [4] = '{chain_excluded, chain_last, chain_first, chain_middle};
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CHAIN_POSITION, 16'(i));
            chk("chain_role", 24'(chain_role), 24'(exp_role[i]));
        end
        e0 = n_ev;
        w0 = n_wd;
        wr(OFS_NEXT_EVENT, 16'h0000);
        wr(OFS_NEXT_WORD, 16'h0000);
        repeat (2) @(negedge core_clk);
        chk("step_auto", 24'(n_ev + n_wd - e0 - w0), 24'h0);
        wr(OFS_MODE_CLEAR, 16'h0800);
        wr(OFS_NEXT_EVENT, 16'h0000);
        repeat (2) @(negedge core_clk);
        chk("next_event", 24'(n_ev - e0), 24'h1);
        wr(OFS_NEXT_WORD, 16'h0000);
        repeat (2) @(negedge core_clk);
        chk("next_word", 24'(n_wd - w0), 24'h1);
        wr(OFS_MODE_SET, 16'h0800);
        $display("test chain and pointer done");
    endtask

    task automatic t_window_reset();
        int o0;
        int m0;
        wr(OFS_FC_WINDOW, 16'h03ff);
        rd_chk("window_clamp", OFS_FC_WINDOW, 16'(FCW_MAX));
        wr(OFS_FC_WINDOW, 16'h0002);
        wait (fast_clear_open === 1'b0);
        @(negedge core_clk);
        o0 = n_open;
        trig(1'b0);
        repeat (1000) @(negedge core_clk);
        chk("window_len", 24'((n_open - o0) inside {[882:884]}), 24'h1);
        wr(OFS_MODE_SET, 16'h0001);
        wr(OFS_IRQ_THRESHOLD, 16'h0005);
        m0 = n_mrst;
        rd_chk("trigger_read", OFS_MODULE_RESET, 16'h0000);
        chk("trigger_read_quiet", 24'(n_mrst - m0), 24'h0);
        wr(OFS_MODULE_RESET, 16'h0000);
        repeat (2) @(negedge core_clk);
        chk("module_reset_pulse", 24'(n_mrst - m0), 24'h1);
        rd_chk("reset_mode", OFS_MODE_SET, MODE_RESET_VALUE);
        rd_chk("reset_threshold", OFS_IRQ_THRESHOLD, 16'h0000);
        $display("test window and reset done");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        wait (reset_n === 1'b1);
        t_mode();
        t_count();
        t_irq_status();
        t_chain_pointer();
        t_window_reset();
        print_verdict();
    end

    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end
endmodule

// file: core/event_counter.sv
`timescale 1ns/10ps
module event_counter
    import qdc_regs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // control
    qdc_ctl_if.counter ctl
);

    // ----------------------------------------
    // 24-bit counter, clear wins over step
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl.count_value <= '0;
        end else if (ctl.count_clear) begin
            ctl.count_value <= '0;
        end else if (ctl.count_step) begin
            ctl.count_value <= ctl.count_value + 24'h000001;
        end
    end

    property p_clear_zero;
        @(posedge core_clk) disable iff (!reset_n)
        ctl.count_clear |=> ctl.count_value == '0;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("counter not cleared");

endmodule

// file: core/fast_clear_window.sv
`timescale 1ns/10ps
module fast_clear_window
    import qdc_regs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // control
    qdc_ctl_if.window ctl
);

    logic [15:0] remaining;

    // ----------------------------------------
    // window length: base plus n steps of 1/32 us
    // ----------------------------------------
    function automatic logic [15:0] window_cycles(input logic [FCW_W-1:0] n);
        logic [31:0] steps;
        steps = 32'(n) * 32'(CLK_MHZ) / 32'(FC_STEP_PER_US);
        return 16'(steps + 32'(FC_BASE_CYCLES));
    endfunction

    // countdown opened by each start strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            remaining <= 16'h0000;
        end else if (ctl.fc_start) begin
            remaining <= window_cycles(ctl.fcw_n);
        end else if (remaining != 16'h0000) begin
            remaining <= remaining - 16'h0001;
        end
    end

    assign ctl.fc_open = (remaining != 16'h0000);

endmodule

// file: core/qdc_ctl_if.sv
`timescale 1ns/10ps
// control bundle between register bank and counter/window modules
interface qdc_ctl_if;
    import qdc_regs_pkg::*;
    logic                 count_clear;
    logic                 count_step;
    logic [COUNT_W-1:0]   count_value;
    logic [FCW_W-1:0]     fcw_n;
    logic                 fc_start;
    logic                 fc_open;
    modport regs    (output count_clear, count_step, fcw_n, fc_start, input count_value, fc_open);
    modport counter (input count_clear, count_step, output count_value);
    modport window  (input fcw_n, fc_start, output fc_open);
endinterface

// file: core/qdc_readout_control_regs.sv
`timescale 1ns/10ps
// Behaviour
// - any write to reset address resets module
// - two chain bits select chain role
// - irq when stored events equal a nonzero threshold
// - status shows buffer empty and full
// - status shows fixed plug-in type code
// - 24-bit counter read as low, high
// - mode bit 14 counts all or accepted
// - counter clears on reset writes, data wipe when counting accepted
// - next-event write jumps pointer to next event
// - next-word write steps pointer one word
// - mode bit 11 selects automatic pointer stepping
// - fast clear window n steps plus 7us
// - mode set write sets ones, reads back
// - mode clear write clears ones
// - two test bits: memory access, synthetic events
// - halt bit stops conversions
// - data-wipe bit generates data reset
// - overflow-check disable stores overflowed data
// - threshold-check disable stores all data
// - threshold shift selects compare window
// - sliding scale enable and subtraction disable
// - empty-event bit writes header and end word
module qdc_readout_control_regs
    import qdc_regs_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    // register port
    input  wire logic [15:0]       reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [15:0]       reg_rdata,
    // acquisition side events
    input  wire logic              any_trigger,
    input  wire logic              accepted_trigger,
    input  wire logic              soft_reset_req,
    input  wire logic [THRESH_W-1:0] events_stored,
    input  wire logic              buffer_empty,
    input  wire logic              buffer_full,
    input  wire logic [3:0]        plugin_type_code,
    input  wire logic              end_of_block_word,
    // controls to the converter and buffer
    output logic                   module_reset_pulse,
    output chain_role_e            chain_role,
    output logic                   irq_request,
    output logic                   pointer_next_event,
    output logic                   pointer_next_word,
    output logic                   data_reset,
    output logic                   memory_test_mode,
    output logic                   synthetic_event_mode,
    output logic                   converter_halt,
    output logic                   store_overflowed,
    output logic                   store_below_threshold,
    output logic                   threshold_window_shift,
    output logic                   sliding_scale_enable,
    output logic                   sliding_sub_disable,
    output logic                   write_empty_events,
    output logic                   fast_clear_open
);

    qdc_ctl_if ctl ();

    logic [CHAIN_W-1:0]  chain_bits;
    logic [THRESH_W-1:0] event_irq_threshold;
    logic [FCW_W-1:0]    fcw_n;
    logic [15:0]         mode;
    logic [15:0]         next_mode;
    logic                irq_armed;

    // ----------------------------------------
    // address decode helper
    // ----------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        return a == ofs;
    endfunction

    // ----------------------------------------
    // module reset trigger
    // ----------------------------------------
    // reset write pulse
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            module_reset_pulse <= 1'b0;
        end else begin
            module_reset_pulse <= reg_write && hit(reg_addr, OFS_MODULE_RESET);
        end
    end

    // ----------------------------------------
    // chain position
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            chain_bits <= '0;
        end else if (module_reset_pulse) begin
            chain_bits <= '0;
        end else if (reg_write && hit(reg_addr, OFS_CHAIN_POSITION)) begin
            chain_bits <= reg_wdata[CHAIN_W-1:0];
        end
    end

    always_comb begin
        case ({chain_bits[1], chain_bits[0]})
            2'b00:   chain_role = chain_excluded;
            2'b10:   chain_role = chain_first;
            2'b01:   chain_role = chain_last;
            default: chain_role = chain_middle;
        endcase
    end

    // ----------------------------------------
    // event threshold and interrupt
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            event_irq_threshold <= '0;
        end else if (module_reset_pulse) begin
            event_irq_threshold <= '0;
        end else if (reg_write && hit(reg_addr, OFS_IRQ_THRESHOLD)) begin
            event_irq_threshold <= reg_wdata[THRESH_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_armed <= 1'b0;
        end else begin
            irq_armed <= (event_irq_threshold != '0) && (events_stored == event_irq_threshold);
        end
    end

    assign irq_request = irq_armed;

    // ----------------------------------------
    // mode register, set and clear addresses
    // ----------------------------------------
    always_comb begin
        next_mode = mode;
        if (reg_write && hit(reg_addr, OFS_MODE_SET)) begin
            next_mode = mode | (reg_wdata & MODE_USED_MASK);
        end else if (reg_write && hit(reg_addr, OFS_MODE_CLEAR)) begin
            next_mode = mode & ~reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode <= MODE_RESET_VALUE;
        end else if (module_reset_pulse) begin
            mode <= MODE_RESET_VALUE;
        end else begin
            mode <= next_mode;
        end
    end

    assign memory_test_mode       = mode[MB_MEM_TEST];
    assign synthetic_event_mode   = mode[MB_SYNTH_EVENT];
    assign converter_halt         = mode[MB_CONV_HALT];
    assign data_reset             = mode[MB_DATA_WIPE];
    assign store_overflowed       = mode[MB_OVF_CHECK_OFF];
    assign store_below_threshold  = mode[MB_THR_CHECK_OFF];
    assign threshold_window_shift = mode[MB_THR_SHIFT];
    assign sliding_scale_enable   = mode[MB_SLIDE_ENABLE];
    assign sliding_sub_disable    = mode[MB_SLIDE_SUB_OFF];
    assign write_empty_events     = mode[MB_EMPTY_EVENTS];

    // ----------------------------------------
    // readout pointer stepping
    // ----------------------------------------
    // next-event and next-word strobes
    // manual strobes only without auto step
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pointer_next_event <= 1'b0;
            pointer_next_word  <= 1'b0;
        end else begin
            pointer_next_event <= reg_write && hit(reg_addr, OFS_NEXT_EVENT) && !mode[MB_AUTO_STEP];
            pointer_next_word  <= reg_write && hit(reg_addr, OFS_NEXT_WORD) && !mode[MB_AUTO_STEP];
        end
    end

    // ----------------------------------------
    // event counter
    // ----------------------------------------
    // counting mode select
    assign ctl.count_step  = mode[MB_COUNT_EVERY] ? any_trigger : accepted_trigger;
    assign ctl.count_clear = (reg_write && hit(reg_addr, OFS_COUNT_RESET)) || soft_reset_req ||
                             module_reset_pulse || (data_reset && !mode[MB_COUNT_EVERY]);

    event_counter u_counter (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .ctl      (ctl.counter)
    );

    // ----------------------------------------
    // fast clear window
    // ----------------------------------------
    // window value, clamped at max
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fcw_n <= '0;
        end else if (module_reset_pulse) begin
            fcw_n <= '0;
        end else if (reg_write && hit(reg_addr, OFS_FC_WINDOW)) begin
            fcw_n <= (reg_wdata[FCW_W-1:0] > FCW_MAX) ? FCW_MAX : reg_wdata[FCW_W-1:0];
        end
    end

    assign ctl.fcw_n    = fcw_n;
    assign ctl.fc_start = any_trigger;

    fast_clear_window u_window (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .ctl      (ctl.window)
    );

    assign fast_clear_open = ctl.fc_open;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // read mux; trigger addresses read zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            if (hit(reg_addr, OFS_IRQ_THRESHOLD)) begin
                reg_rdata <= 16'(event_irq_threshold);
            end else if (hit(reg_addr, OFS_BUFFER_STATUS)) begin
                reg_rdata <= 16'({plugin_type_code, 2'b00, buffer_full, buffer_empty});
            end else if (hit(reg_addr, OFS_COUNT_LOW)) begin
                reg_rdata <= ctl.count_value[15:0];
            end else if (hit(reg_addr, OFS_COUNT_HIGH)) begin
                reg_rdata <= 16'(ctl.count_value[COUNT_W-1:16]);
            end else if (hit(reg_addr, OFS_FC_WINDOW)) begin
                reg_rdata <= 16'(fcw_n);
            end else if (hit(reg_addr, OFS_MODE_SET)) begin
                reg_rdata <= mode;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_reset_write;
        @(posedge core_clk) disable iff (!reset_n)
        reg_write && reg_addr == OFS_MODULE_RESET |=> module_reset_pulse ##1 mode == MODE_RESET_VALUE;
    endproperty
    a_reset_write: assert property (p_reset_write) else $error("reset write ignored");

    property p_chain_role;
        @(posedge core_clk) disable iff (!reset_n)
        chain_bits == 2'b10 |-> chain_role == chain_first;
    endproperty
    a_chain_role: assert property (p_chain_role) else $error("chain role wrong");

    property p_irq_zero;
        @(posedge core_clk) disable iff (!reset_n)
        event_irq_threshold == '0 |=> !irq_request;
    endproperty
    a_irq_zero: assert property (p_irq_zero) else $error("irq with zero threshold");

    property p_irq_eq;
        @(posedge core_clk) disable iff (!reset_n)
        event_irq_threshold != '0 && events_stored == event_irq_threshold |=> irq_request;
    endproperty
    a_irq_eq: assert property (p_irq_eq) else $error("irq missing");

    property p_status_read;
        @(posedge core_clk) disable iff (!reset_n)
        reg_read && reg_addr == OFS_BUFFER_STATUS |=> reg_rdata[SS_FULL] == $past(buffer_full)
            && reg_rdata[SS_EMPTY] == $past(buffer_empty);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    property p_mode_set;
        @(posedge core_clk) disable iff (!reset_n)
        reg_write && reg_addr == OFS_MODE_SET && !module_reset_pulse
            |=> (mode & ($past(reg_wdata) & MODE_USED_MASK)) == ($past(reg_wdata) & MODE_USED_MASK);
    endproperty
    a_mode_set: assert property (p_mode_set) else $error("mode set failed");

    property p_mode_clear;
        @(posedge core_clk) disable iff (!reset_n)
        reg_write && reg_addr == OFS_MODE_CLEAR && !module_reset_pulse |=> (mode & $past(reg_wdata)) == 16'h0000;
    endproperty
    a_mode_clear: assert property (p_mode_clear) else $error("mode clear failed");

    property p_manual_step;
        @(posedge core_clk) disable iff (!reset_n)
        mode[MB_AUTO_STEP] |=> !pointer_next_word && !pointer_next_event;
    endproperty
    a_manual_step: assert property (p_manual_step) else $error("strobe in auto mode");

    property p_wipe_count;
        @(posedge core_clk) disable iff (!reset_n)
        data_reset && !mode[MB_COUNT_EVERY] |=> ctl.count_value == '0;
    endproperty
    a_wipe_count: assert property (p_wipe_count) else $error("counter survived wipe");

    property p_fcw_limit;
        @(posedge core_clk) disable iff (!reset_n)
        fcw_n <= FCW_MAX;
    endproperty
    a_fcw_limit: assert property (p_fcw_limit) else $error("window above max");

    property p_next_event;
        @(posedge core_clk) disable iff (!reset_n)
        reg_write && reg_addr == OFS_NEXT_EVENT && !mode[MB_AUTO_STEP] |=> pointer_next_event;
    endproperty
    a_next_event: assert property (p_next_event) else $error("next event lost");

    property p_read_quiet;
        @(posedge core_clk) disable iff (!reset_n)
        reg_read && !reg_write |=> !module_reset_pulse;
    endproperty
    a_read_quiet: assert property (p_read_quiet) else $error("read caused reset");

endmodule

// file: core/qdc_regs_pkg.sv
package qdc_regs_pkg;

    // ----------------------------------------
    // register offsets (byte addresses, 16-bit words)
    // ----------------------------------------
    localparam logic [15:0] OFS_MODULE_RESET   = 16'h1016;
    localparam logic [15:0] OFS_CHAIN_POSITION = 16'h101a;
    localparam logic [15:0] OFS_IRQ_THRESHOLD  = 16'h1020;
    localparam logic [15:0] OFS_BUFFER_STATUS  = 16'h1022;
    localparam logic [15:0] OFS_COUNT_LOW      = 16'h1024;
    localparam logic [15:0] OFS_COUNT_HIGH     = 16'h1026;
    localparam logic [15:0] OFS_NEXT_EVENT     = 16'h1028;
    localparam logic [15:0] OFS_NEXT_WORD      = 16'h102a;
    localparam logic [15:0] OFS_FC_WINDOW      = 16'h102e;
    localparam logic [15:0] OFS_MODE_SET       = 16'h1032;
    localparam logic [15:0] OFS_MODE_CLEAR     = 16'h1034;
    localparam logic [15:0] OFS_COUNT_RESET    = 16'h1040;

    // ----------------------------------------
    // mode register fields
    // ----------------------------------------
    localparam int MB_MEM_TEST       = 0;
    localparam int MB_CONV_HALT      = 1;
    localparam int MB_DATA_WIPE      = 2;
    localparam int MB_OVF_CHECK_OFF  = 3;
    localparam int MB_THR_CHECK_OFF  = 4;
    localparam int MB_SYNTH_EVENT    = 6;
    localparam int MB_SLIDE_ENABLE   = 7;
    localparam int MB_THR_SHIFT      = 8;
    localparam int MB_AUTO_STEP      = 11;
    localparam int MB_EMPTY_EVENTS   = 12;
    localparam int MB_SLIDE_SUB_OFF  = 13;
    localparam int MB_COUNT_EVERY    = 14;
    localparam logic [15:0] MODE_RESET_VALUE = 16'h4880;
    localparam logic [15:0] MODE_USED_MASK   = 16'h79df;

    // ----------------------------------------
    // field widths, identity, timing
    // ----------------------------------------
    localparam int THRESH_W  = 5;
    localparam int COUNT_W   = 24;
    localparam int FCW_W     = 10;
    localparam int CHAIN_W   = 2;
    localparam logic [3:0] PLUGIN_TYPE_DEFAULT = 4'h5; // arbitrary value
    localparam int SS_EMPTY  = 0;
    localparam int SS_FULL   = 1;
    localparam int SS_PLUGIN = 4;
    localparam int CLK_MHZ        = 125;
    localparam int FC_BASE_US     = 7;
    localparam int FC_STEP_PER_US = 32;
    localparam int FC_BASE_CYCLES = FC_BASE_US * CLK_MHZ;
    localparam logic [FCW_W-1:0] FCW_MAX = 10'h3f0;

    typedef enum logic [1:0] {chain_excluded, chain_first, chain_last, chain_middle} chain_role_e;

endpackage
